//--- design/adf_pkg.sv
// Constants, register map and settings of the decimation filter chain.
// Assumes one system clock; register access arrives on a plain write/read port.
// Overview of operation
// - Overrange stops all sensor drive clocks for 0.5 ms.
// - Trip level near 8 g in lowest range, 16 g otherwise.
// - During protection outputs decay to zero and are still buffered.
// - Self test: enable first, then force; clear both to resume.
// - Self-test controls are bits of register 0x2E.
// - Low-pass decimator plus bypassable high-pass; rates 4 kHz to 3.9 Hz.
// - First stage always decimates to 4 kHz, about 1 kHz corner.
// - Second stage used at 2 kHz and below, bypassed at 4 kHz.
// - Rates are 4000 Hz over powers of two down to divide-by-1024.
// - Delay counted from converter entry to readable result.
// - High-pass is off after reset.
// - High-pass corner is bits 6 to 4 of filter_settings.
// - Corner code zero disables; codes 1 to 6 give shrinking corners.
// - Interpolator upsamples to 64 times the output rate.
// - Interpolated delay about 3.5 down to 2.5 output cycles.
// - Power-up: high-pass off, 1 kHz low-pass, 4000 Hz output rate.
// - Output rate is written into filter_settings.
package adf_pkg;
    localparam int unsigned CLK_HZ           = 20_000_000;
    localparam int unsigned ADC_HZ           = 256_000;
    localparam int unsigned BASE_HZ          = 4_000;
    localparam int unsigned STAGE1_RATIO     = ADC_HZ / BASE_HZ;
    localparam int unsigned PROTECT_US       = 500;
    localparam int unsigned PROTECT_CYCLES   = PROTECT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned INTERP_FACTOR    = 64;
    localparam logic [7:0]  FILTER_ADDR      = 8'h28;
    localparam logic [7:0]  CHECK_ADDR       = 8'h2E;
    localparam logic [7:0]  FILTER_RESET     = 8'h00;
    localparam logic [7:0]  CHECK_RESET      = 8'h00;
    localparam int unsigned RATE_LSB         = 0;
    localparam int unsigned CORNER_LSB       = 4;
    localparam int unsigned INTERP_BIT       = 7;
    localparam logic [3:0]  RATE_MAX         = 4'hA;
    localparam int unsigned CHECK_EN_BIT     = 0;
    localparam int unsigned CHECK_FORCE_BIT  = 1;
    localparam logic [19:0] TRIP_LOW_RANGE   = 20'h40000;
    localparam logic [19:0] TRIP_HIGH_RANGE  = 20'h7FFFF;
    localparam int unsigned DECAY_SHIFT      = 4;
    // Corner code -> shift k, pole = 2^-k per output sample
    localparam logic [4:0]  CORNER_SHIFT [7] = '{5'h00, 5'h07, 5'h09, 5'h0B,
                                                 5'h0D, 5'h0F, 5'h11};
endpackage : adf_pkg

//--- design/adf_buf_if.sv
// Carrier between the filter core and its two-entry output buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface adf_buf_if #(parameter int W = 60);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src  (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : adf_buf_if
`default_nettype wire

//--- design/adf_skid_buf.sv
// Two-entry buffer between the filter core and the result port.
// Assumes the reader may stall any number of cycles.
`timescale 1ns/100ps
`default_nettype none
module adf_skid_buf #(
    parameter int W = 60
) (
    input  wire logic         clk_sys_in,
    input  wire logic         rst_in,
    adf_buf_if.sink           up,
    output logic              valid_out,
    output logic [W-1:0]      data_out,
    input  wire logic         ready_in
);
    logic [W-1:0] mem [2];
    logic         wp;
    logic         rp;
    logic [1:0]   cnt;
    logic         push;
    logic         pop;

    assign up.ready = (cnt != 2'h2);
    assign push     = up.valid && up.ready;
    assign pop      = valid_out && ready_in;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wp  <= 1'b0;
            rp  <= 1'b0;
            cnt <= 2'h0;
        end else begin
            if (push) wp <= ~wp;
            if (pop) rp <= ~rp;
            cnt <= cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (push) mem[wp] <= up.data;
    end

    // Output is registered so the read port never sees combinational data
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            valid_out <= 1'b0;
            data_out  <= '0;
        end else if (!valid_out || ready_in) begin
            valid_out <= (cnt - {1'b0, pop}) != 2'h0;
            data_out  <= mem[pop ? ~rp : rp];
        end
    end

    buf_level_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        cnt <= 2'h2) else $error("buffer count beyond two");
endmodule : adf_skid_buf
`default_nettype wire

//--- design/adf_filter_chain.sv
// Top of the digital filter chain: three axes of 20-bit converter samples,
// decimation to the programmed rate, optional high-pass and interpolation.
// Assumes converter samples arrive on clk_sys_in as single-cycle strobes.
`timescale 1ns/100ps
`default_nettype none
module adf_filter_chain
    import adf_pkg::*;
#(
    parameter int unsigned PROTECT_LEN = PROTECT_CYCLES
) (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        adc_valid_in,
    input  wire logic [59:0] adc_data_in,
    input  wire logic        high_range_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic [7:0]       reg_rdata_out,
    output logic             check_mode_enable_out,
    output logic             check_force_apply_out,
    output logic             drive_clk_en_out,
    output logic             sample_valid_out,
    output logic [59:0]      sample_data_out,
    input  wire logic        sample_ready_in,
    output logic             interp_strobe_out
);
    if (PROTECT_LEN < 1) begin : g_len_check
        $error("protection length must be positive");
    end

    typedef enum logic [1:0] {
        ADF_RUN     = 2'b01,
        ADF_PROTECT = 2'b10
    } adf_state_e;

    adf_state_e  state;
    logic [7:0]  filter_settings;
    logic [7:0]  mechanical_check_control;
    logic [3:0]  output_sample_rate;
    logic [2:0]  highpass_corner_select;
    logic        interp_enable;
    logic        settings_change;
    logic [31:0] protect_cnt;
    logic        over_any;
    logic [5:0]  s1_cnt;
    logic [9:0]  s2_cnt;
    logic [9:0]  s2_len;
    logic        s1_done;
    logic        s2_done;
    logic [9:0]  interp_cnt;
    logic [9:0]  interp_len;
    logic        out_push;
    logic [59:0] out_word;

    adf_buf_if #(.W(60)) bif ();

    assign output_sample_rate     = filter_settings[RATE_LSB +: 4];
    assign highpass_corner_select = filter_settings[CORNER_LSB +: 3];
    assign interp_enable          = filter_settings[INTERP_BIT];
    assign s1_done = adc_valid_in && (s1_cnt == 6'(STAGE1_RATIO - 1));
    assign s2_len  = 10'h3FF >> (4'hA - output_sample_rate);
    assign s2_done = s1_done && (s2_cnt == s2_len);

    function automatic logic tripped(input logic [19:0] v, input logic hi);
        logic [19:0] mag;
        mag = v[19] ? (~v + 20'h00001) : v;
        tripped = hi ? (mag >= TRIP_HIGH_RANGE) : (mag >= TRIP_LOW_RANGE);
    endfunction : tripped

    assign over_any = adc_valid_in &&
        (tripped(adc_data_in[19:0], high_range_in) ||
         tripped(adc_data_in[39:20], high_range_in) ||
         tripped(adc_data_in[59:40], high_range_in));

    // Register writes; rate index above ten is refused and kept
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            filter_settings <= FILTER_RESET;
            settings_change <= 1'b0;
        end else begin
            settings_change <= 1'b0;
            if (reg_wr_in && reg_addr_in == FILTER_ADDR &&
                reg_wdata_in[3:0] <= RATE_MAX) begin
                filter_settings <= reg_wdata_in;
                settings_change <= (reg_wdata_in != filter_settings);
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mechanical_check_control <= CHECK_RESET;
        end else if (reg_wr_in && reg_addr_in == CHECK_ADDR) begin
            mechanical_check_control <= {6'h00, reg_wdata_in[1:0]};
        end
    end

    // Force is honoured only while enable is set
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            check_mode_enable_out <= 1'b0;
            check_force_apply_out <= 1'b0;
        end else begin
            check_mode_enable_out <= mechanical_check_control[CHECK_EN_BIT];
            check_force_apply_out <=
                mechanical_check_control[CHECK_EN_BIT] &&
                mechanical_check_control[CHECK_FORCE_BIT];
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                FILTER_ADDR: reg_rdata_out <= filter_settings;
                CHECK_ADDR:  reg_rdata_out <= mechanical_check_control;
                default:     reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // Overrange protection
    // A new trip during protection does not extend the hold-off period
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state       <= ADF_RUN;
            protect_cnt <= '0;
        end else begin
            case (state)
                ADF_RUN: begin
                    if (over_any) begin
                        state       <= ADF_PROTECT;
                        protect_cnt <= 32'(PROTECT_LEN - 1);
                    end
                end
                ADF_PROTECT: begin
                    if (protect_cnt == '0) state <= ADF_RUN;
                    else protect_cnt <= protect_cnt - 32'h1;
                end
                default: state <= ADF_RUN;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) drive_clk_en_out <= 1'b1;
        else drive_clk_en_out <= !(over_any || (state == ADF_PROTECT &&
                                  protect_cnt != '0));
    end

    // Decimation counters
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s1_cnt <= '0;
            s2_cnt <= '0;
        end else if (settings_change) begin
            s1_cnt <= '0;
            s2_cnt <= '0;
        end else if (adc_valid_in) begin
            s1_cnt <= s1_done ? 6'h00 : s1_cnt + 6'h01;
            if (s1_done) s2_cnt <= s2_done ? 10'h000 : s2_cnt + 10'h001;
        end
    end

    // Per-axis datapath: boxcar decimators, high-pass, decay in protection
    genvar ax;
    for (ax = 0; ax < 3; ax++) begin : g_axis
        logic signed [25:0] acc1;
        logic signed [19:0] st1_next;
        logic signed [29:0] acc2;
        logic signed [19:0] dec;
        logic signed [19:0] sample_in;
        logic signed [39:0] hp_state;
        logic signed [19:0] hp_out;
        logic signed [19:0] result;
        logic signed [19:0] hold;

        assign sample_in = (state == ADF_PROTECT) ?
            (hold - (hold >>> DECAY_SHIFT)) :
            signed'(adc_data_in[ax*20 +: 20]);
        // Stage two adds this sample's stage-one result before scaling, so
        // a constant input comes out at unit gain at every rate
        assign st1_next = 20'((acc1 + 26'(sample_in)) >>> 6);
        assign dec = (output_sample_rate == 4'h0) ? st1_next :
            20'((acc2 + 30'(st1_next)) >>> output_sample_rate);
        assign hp_out = (highpass_corner_select == 3'h0 ||
                         highpass_corner_select == 3'h7) ? dec :
            20'(dec - 20'(hp_state >>> 20));

        always_ff @(posedge clk_sys_in or posedge rst_in) begin
            if (rst_in) begin
                acc1 <= '0; acc2 <= '0;
                hp_state <= '0; result <= '0; hold <= '0;
            end else if (settings_change) begin
                acc1 <= '0; acc2 <= '0; hp_state <= '0;
            end else if (adc_valid_in) begin
                if (state == ADF_PROTECT) hold <= sample_in;
                else hold <= result;
                acc1 <= s1_done ? 26'sh0 : acc1 + 26'(sample_in);
                if (s1_done) begin
                    acc2 <= s2_done ? 30'sh0 : acc2 + 30'(st1_next);
                end
                if (s2_done) begin
                    result <= hp_out;
                    hp_state <= hp_state + 40'((40'(hp_out) <<< 20) >>>
                        CORNER_SHIFT[highpass_corner_select[2:0] == 3'h7 ?
                        3'h0 : highpass_corner_select]);
                end
            end
        end
        assign out_word[ax*20 +: 20] = hp_out;
    end

    // Result push into the buffer; while the buffer is full a new result
    // overwrites the one still waiting in bif.data, so results can be lost
    assign out_push = s2_done && adc_valid_in && !settings_change;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            bif.valid <= 1'b0;
            bif.data  <= '0;
        end else begin
            if (out_push) begin
                bif.valid <= 1'b1;
                bif.data  <= out_word;
            end else if (bif.ready) begin
                bif.valid <= 1'b0;
            end
        end
    end

    // Interpolation strobes: 64 evenly spaced ticks per output period
    assign interp_len = s2_len;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            interp_cnt        <= '0;
            interp_strobe_out <= 1'b0;
        end else begin
            interp_strobe_out <= 1'b0;
            if (!interp_enable || settings_change) begin
                interp_cnt <= '0;
            end else if (adc_valid_in) begin
                // One tick every 2^rate converter samples: 64 per period
                interp_strobe_out <= (interp_cnt == 10'h000);
                interp_cnt <= (interp_cnt == interp_len) ? 10'h000 :
                    interp_cnt + 10'h001;
            end
        end
    end

    adf_skid_buf #(.W(60)) u_buf (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .up         (bif.sink),
        .valid_out  (sample_valid_out),
        .data_out   (sample_data_out),
        .ready_in   (sample_ready_in)
    );

    protect_start_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        state == ADF_RUN && over_any |=> state == ADF_PROTECT)
        else $error("protection did not start");
    drive_off_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        state == ADF_PROTECT && protect_cnt > 1 |=> !drive_clk_en_out)
        else $error("drive clocks running in protection");
    hp_reset_a: assert property (@(posedge clk_sys_in)
        $fell(rst_in) |-> highpass_corner_select == 3'h0)
        else $error("high-pass on after reset");
    force_gate_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        check_force_apply_out |-> check_mode_enable_out)
        else $error("force without enable");
    check_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_wr_in && reg_addr_in == CHECK_ADDR |=>
        mechanical_check_control[1:0] == $past(reg_wdata_in[1:0]))
        else $error("self-test register not written");
    rate_range_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        output_sample_rate <= RATE_MAX)
        else $error("rate index out of range");
    change_clear_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        settings_change |=> s1_cnt == 6'h00 && s2_cnt == 10'h000)
        else $error("filter state not cleared");
    bypass_fast_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        output_sample_rate == 4'h0 |-> s2_done == s1_done)
        else $error("second stage not bypassed");
    push_out_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        out_push |=> bif.valid)
        else $error("result not offered");
    drive_back_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        state == ADF_PROTECT && protect_cnt == '0 && !over_any |=>
        drive_clk_en_out) else $error("drive clocks not restored");
    interp_off_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        !interp_enable |=> !interp_strobe_out)
        else $error("interpolation tick while disabled");
    rate_keep_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        reg_wr_in && reg_addr_in == FILTER_ADDR &&
        reg_wdata_in[3:0] > RATE_MAX |=> $stable(filter_settings))
        else $error("bad rate index accepted");
    cov_slow_rate: cover property (@(posedge clk_sys_in)
        out_push && output_sample_rate == 4'h2);
    cov_protect: cover property (@(posedge clk_sys_in) state == ADF_PROTECT);
    cov_out: cover property (@(posedge clk_sys_in) sample_valid_out);
    cov_selftest: cover property (@(posedge clk_sys_in) check_force_apply_out);
    cov_interp: cover property (@(posedge clk_sys_in) interp_strobe_out);
endmodule : adf_filter_chain
`default_nettype wire

//--- dv/adf_reader_model.sv
// Host-side reader of filtered result words.
// Assumes the result port holds valid and data until they are taken.
`timescale 1ns/100ps
`default_nettype none
module adf_reader_model (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        valid_in,
    input  wire logic [59:0] data_in,
    input  wire logic        stall_in,
    output logic             ready_out,
    output int unsigned      count_out,
    output logic [59:0]      last_out
);
    // Ready moves only after an edge, so a stall never cuts a word in half
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ready_out <= 1'b0;
        end else begin
            ready_out <= !stall_in;
        end
    end
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            count_out <= 0;
            last_out  <= '0;
        end else if (valid_in && ready_out) begin
            count_out <= count_out + 1;
            last_out  <= data_in;
        end
    end
endmodule : adf_reader_model
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the filter chain top with a reader model.
// Assumes one 20 MHz clock and a shortened protection count.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import adf_pkg::*;
    localparam int unsigned PLEN = 20;
    logic clk_sys_in = 0, rst_in = 1, adc_valid_in = 0, high_range_in = 0;
    logic reg_wr_in = 0, reg_rd_in = 0, stall = 0, hold = 0;
    logic [59:0] adc_data_in = '0;
    logic [7:0]  reg_addr_in = '0, reg_wdata_in = '0, reg_rdata_out, d;
    logic        check_mode_enable_out, check_force_apply_out, ready;
    logic        drive_clk_en_out, sample_valid_out, interp_strobe_out;
    logic [59:0] sample_data_out, last, keep;
    logic [31:0] seed = 32'h0001641E;
    logic [19:0] v;
    int unsigned count, c0, n, icount = 0, checks = 0, fail_count = 0;
    adf_filter_chain #(.PROTECT_LEN(PLEN)) i_dut (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .adc_valid_in(adc_valid_in),
        .adc_data_in(adc_data_in), .high_range_in(high_range_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out),
        .check_mode_enable_out(check_mode_enable_out),
        .check_force_apply_out(check_force_apply_out),
        .drive_clk_en_out(drive_clk_en_out),
        .sample_valid_out(sample_valid_out),
        .sample_data_out(sample_data_out), .sample_ready_in(ready),
        .interp_strobe_out(interp_strobe_out));
    adf_reader_model i_reader (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .valid_in(sample_valid_out), .data_in(sample_data_out),
        .stall_in(stall), .ready_out(ready), .count_out(count),
        .last_out(last));
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd
    function automatic int unsigned per(input int unsigned r);
        return STAGE1_RATIO << r;
    endfunction : per
    function automatic logic near(input logic [19:0] a, input logic [19:0] b);
        logic [19:0] t;
        t = a - b;
        return (t < 20'h00005) || (t > 20'hFFFFB);
    endfunction : near
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen,
                     exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk_sys_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= x;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        @(posedge clk_sys_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        @(posedge clk_sys_in);
        #1 x = reg_rdata_out;
    endtask : rd
    // Strobes spaced ten cycles apart keep the run short
    task automatic feed(input int unsigned k, input logic [59:0] x);
        repeat (k) begin
            @(posedge clk_sys_in);
            adc_valid_in <= 1'b1;
            adc_data_in  <= x;
            @(posedge clk_sys_in);
            adc_valid_in <= 1'b0;
            repeat (8) @(posedge clk_sys_in);
        end
    endtask : feed
    initial begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    // Reader stalls one cycle in eight, or throughout while hold is set
    always @(posedge clk_sys_in) begin
        stall <= hold | (rnd() % 8 == 0);
        if (interp_strobe_out === 1'b1) icount++;
    end
    initial begin
        repeat (100000) @(posedge clk_sys_in);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        #1 check(drive_clk_en_out, 1'b1);
        rd(FILTER_ADDR, d);
        check(d, 8'h00);
        rd(CHECK_ADDR, d);
        check(d, 8'h00);
        rd(8'h10, d);
        check(d, 8'h00);
        for (int i = 0; i < 6; i++) begin
            c0 = (i == 0) ? 10 : rnd() % 11;
            keep[7:0] = {rnd() % 2 == 0, 3'(rnd() % 7), 4'(c0)};
            wr(FILTER_ADDR, keep[7:0]);
            rd(FILTER_ADDR, d);
            check(d, keep[7:0]);
            wr(FILTER_ADDR, {keep[7:4], 4'hB + 4'(i % 5)});
            rd(FILTER_ADDR, d);
            check(d, keep[7:0]);
        end
        for (int i = 0; i < 4; i++) begin
            wr(CHECK_ADDR, 8'(i));
            rd(CHECK_ADDR, d);
            check(d, 8'(i));
            check(check_mode_enable_out, i[0]);
            check(check_force_apply_out, i[0] & i[1]);
        end
        wr(CHECK_ADDR, 8'h00);
        for (int r = 0; r < 3; r++) begin
            v = {3'h0, 17'(rnd())};
            wr(FILTER_ADDR, 8'(r));
            c0 = count;
            feed(6 * per(r), {v, v, v});
            n = count - c0;
            check(n >= 5 && n <= 7, 1'b1);
            check(near(last[19:0], v) && near(last[59:40], v), 1'b1);
        end
        wr(FILTER_ADDR, 8'h00);
        hold <= 1'b1;
        feed(3 * per(0), '0);
        #1 c0 = count;
        keep = sample_data_out;
        feed(per(0), '0);
        #1 check(sample_valid_out, 1'b1);
        check(sample_data_out, keep);
        hold <= 1'b0;
        repeat (20) @(posedge clk_sys_in);
        #1 n = count - c0;
        check(n >= 2 && n <= 3, 1'b1);
        // Third pass lies between the two trip levels, fourth trips high
        for (int i = 0; i < 4; i++) begin
            v = (i == 1) ? 20'h80001 : (i == 2) ? 20'h7FFFE :
                (i == 3) ? 20'h80000 : 20'h7FFFF;
            @(posedge clk_sys_in);
            high_range_in <= (i >= 2);
            adc_valid_in  <= 1'b1;
            adc_data_in   <= {40'h0, v};
            @(posedge clk_sys_in);
            adc_valid_in  <= 1'b0;
            n = 0;
            for (int k = 0; k < 60; k++) begin
                #1 if (drive_clk_en_out !== 1'b1) n++;
                @(posedge clk_sys_in);
            end
            #1 check(n, (i == 2) ? 0 : PLEN);
            check(drive_clk_en_out, 1'b1);
            feed(per(0), '0);
        end
        high_range_in <= 1'b0;
        wr(FILTER_ADDR, 8'h81);
        feed(per(1), '0);
        c0 = icount;
        feed(4 * per(1), '0);
        n = icount - c0;
        check(n + 2 >= 4 * INTERP_FACTOR && n <= 4 * INTERP_FACTOR + 2, 1);
        summarize();
    end
endmodule : testbench
`default_nettype wire
